// File: rtl/timer_regs.svh
// register offsets, field positions, reset values and divider counts for the timer block
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// register addresses on the special-function register port
`define ADDR_RUN_FLAG      8'h88
`define ADDR_MODE          8'h89
`define ADDR_T0_LOW        8'h8A
`define ADDR_T1_LOW        8'h8B
`define ADDR_T0_HIGH       8'h8C
`define ADDR_T1_HIGH       8'h8D
`define ADDR_CLOCK_SELECT  8'h8E

// reset values
`define RESET_BYTE         8'h00

// clock select fields
`define CKS_DIV_LSB        0
`define CKS_DIV_MSB        1
`define CKS_T0_PICK        2
`define CKS_T1_PICK        3
`define CKS_T2_LOW         4
`define CKS_T2_HIGH        5
`define CKS_T3_LOW         6
`define CKS_T3_HIGH        7

// run and flag fields
`define RF_T0_RUN          4
`define RF_T0_FLAG         5
`define RF_T1_RUN          6
`define RF_T1_FLAG         7

// mode register fields
`define MD_T0_LSB          0
`define MD_T0_MSB          1
`define MD_T0_COUNT        2
`define MD_T0_GATE         3
`define MD_T1_LSB          4
`define MD_T1_MSB          5
`define MD_T1_COUNT        6
`define MD_T1_GATE         7

// shared divider ratios, as terminal counts
`define DIV_SYS_12_LAST    4'hB
`define DIV_SYS_4_LAST     2'h3
`define DIV_SYS_48_LAST    6'h2F
`define DIV_EXT_8_LAST     3'h7

`endif

// File: rtl/timer_pkg.sv
// types shared by the timer block
package timer_pkg;

    // operating mode of the first and second timer
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } mode_t;

    // shared divider selection
    typedef enum logic [1:0] {
        DIV_SYS_12,
        DIV_SYS_4,
        DIV_SYS_48,
        DIV_EXT_8
    } div_sel_t;

endpackage

// File: rtl/tick_if.sv
// divided tick strobes passed from the prescaler to the timer core
`timescale 1ns/1ns
interface tick_if;
    logic div12_tick;   // system clock / 12
    logic div4_tick;    // system clock / 4
    logic div48_tick;   // system clock / 48
    logic ext8_tick;    // synchronised external clock / 8
    logic shared_tick;  // output of the shared divider select

    modport src (output div12_tick, div4_tick, div48_tick, ext8_tick, shared_tick);
    modport snk (input  div12_tick, div4_tick, div48_tick, ext8_tick, shared_tick);
endinterface

// File: rtl/pin_sync.sv
// two-flop synchroniser with level and edge outputs for one pin
`timescale 1ns/1ns
module pin_sync (
    input  wire logic sys_clk,   // system clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic pin,       // asynchronous pin
    output logic      level,     // synchronised level
    output logic      fall,      // one-cycle pulse on high-to-low
    output logic      rise       // one-cycle pulse on low-to-high
);
    logic meta_r, sync_r, prev_r;       // stage flops
    logic meta_nxt, sync_nxt, prev_nxt; // next values

    // shift chain; meta_r feeds only sync_r
    always_comb begin
        meta_nxt = pin;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // idle high so that a released pin is not seen as an edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // edges are level changes between consecutive samples
    assign level = sync_r;
    assign fall  = prev_r & ~sync_r;
    assign rise  = ~prev_r & sync_r;
endmodule

// File: rtl/prescaler.sv
// shared clock divider producing one-cycle ticks
`timescale 1ns/1ns
`include "timer_regs.svh"
module prescaler (
    input  wire logic               sys_clk,   // system clock
    input  wire logic               rst_n,     // async reset, active low
    input  wire timer_pkg::div_sel_t div_sel,  // shared divider select
    input  wire logic               ext_rise,  // synchronised external clock edge
    tick_if.src                     ticks      // divided tick strobes
);
    import timer_pkg::*;

    logic [3:0] c12_r, c12_nxt;  // divide-by-12 counter
    logic [1:0] c4_r,  c4_nxt;   // divide-by-4 counter
    logic [5:0] c48_r, c48_nxt;  // divide-by-48 counter
    logic [2:0] c8_r,  c8_nxt;   // external divide-by-8 counter

    // free-running counters; ext counter moves only on external edges
    always_comb begin
        c12_nxt = (c12_r == `DIV_SYS_12_LAST) ? 4'h0 : c12_r + 4'h1;
        c4_nxt  = c4_r + 2'h1;
        c48_nxt = (c48_r == `DIV_SYS_48_LAST) ? 6'h00 : c48_r + 6'h01;
        c8_nxt  = ext_rise ? c8_r + 3'h1 : c8_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c12_r <= 4'h0;
            c4_r  <= 2'h0;
            c48_r <= 6'h00;
            c8_r  <= 3'h0;
        end else begin
            c12_r <= c12_nxt;
            c4_r  <= c4_nxt;
            c48_r <= c48_nxt;
            c8_r  <= c8_nxt;
        end
    end

    // ticks fire on the terminal count of each divider
    assign ticks.div12_tick = (c12_r == `DIV_SYS_12_LAST);
    assign ticks.div4_tick  = (c4_r == `DIV_SYS_4_LAST);
    assign ticks.div48_tick = (c48_r == `DIV_SYS_48_LAST);
    assign ticks.ext8_tick  = ext_rise & (c8_r == `DIV_EXT_8_LAST);

    // shared select; ext/8 is already synchronous to sys_clk
    always_comb begin
        case (div_sel)
            DIV_SYS_12: ticks.shared_tick = ticks.div12_tick;  // R1
            DIV_SYS_4:  ticks.shared_tick = ticks.div4_tick;   // R1
            DIV_SYS_48: ticks.shared_tick = ticks.div48_tick;  // R1
            DIV_EXT_8:  ticks.shared_tick = ticks.ext8_tick;   // R1
            default:    ticks.shared_tick = ticks.div12_tick;
        endcase
    end
endmodule

// File: rtl/dual_timer_counter.sv
// two classic counter/timers with clock select and shared prescaler
// Summary of operation
// R1 - prescaler divides sys 12/4/48, ext 8
// R2 - second timer clock pick, ignored when counting
// R3 - first timer clock pick, ignored when counting
// R4 - third timer byte picks: sys or own
// R5 - fourth timer byte picks: sys or own
// R6 - 16-bit count held as two bytes
// R7 - 13-bit: high byte plus low five bits
// R8 - 13-bit wrap sets overflow flag, irq
// R9 - count-select counts falling event pin edges
// R10 - run bit and optional gate pin polarity
// R11 - run bit does not clear count
// R12 - second timer gated by second irq input
// R13 - 16-bit mode uses all sixteen bits
// R14 - 8-bit reload from high byte on overflow
// R15 - software preloads low byte before run
// R16 - split low byte uses first timer controls
// R17 - split high byte: internal clock, second run/flag
// R18 - split: second timer no pins, no flag
// R19 - split: second runs in modes 0-2 only
// R20 - second timer holds in mode 3
// R21 - each timer has own mode field
// R22 - flag set by hw, sw and vector clear
// R23 - event pins held two clocks minimum
// R24 - mode 00 selects 13-bit counting
// R25 - pins sampled, one step per clock
// R26 - software byte write beats hardware update
`timescale 1ns/1ns
`include "timer_regs.svh"
module dual_timer_counter (
    input  wire logic       sys_clk,                     // 100 MHz system clock
    input  wire logic       rst_n,                       // async reset, active low
    input  wire logic [7:0] sfr_addr,                    // register address
    input  wire logic       sfr_wr_en,                   // write strobe
    input  wire logic       sfr_rd_en,                   // read strobe
    input  wire logic [7:0] sfr_wdata,                   // write data
    output logic      [7:0] sfr_rdata,                   // read data, next cycle
    input  wire logic       first_event_pin,             // first timer event pin
    input  wire logic       second_event_pin,            // second timer event pin
    input  wire logic       first_external_irq_input,    // first gate pin
    input  wire logic       second_external_irq_input,   // second gate pin
    input  wire logic       ext_osc_clk,                 // external clock pin
    input  wire logic       first_irq_polarity,          // 1: gate pin active high
    input  wire logic       second_irq_polarity,         // 1: gate pin active high
    input  wire logic       first_timer_irq_enable,      // first overflow irq enable
    input  wire logic       second_timer_irq_enable,     // second overflow irq enable
    input  wire logic       first_timer_irq_ack,         // vector taken, pulse
    input  wire logic       second_timer_irq_ack,        // vector taken, pulse
    input  wire logic       third_timer_ext_clock_bit,   // third timer own source
    input  wire logic       fourth_timer_ext_clock_bit,  // fourth timer own source
    output logic            first_timer_irq_req,         // first overflow request
    output logic            second_timer_irq_req,        // second overflow request
    output logic            second_timer_overflow_tick,  // second overflow, pulse
    output logic            third_timer_low_tick,        // third timer low byte tick
    output logic            third_timer_high_tick,       // third timer high byte tick
    output logic            fourth_timer_low_tick,       // fourth timer low byte tick
    output logic            fourth_timer_high_tick       // fourth timer high byte tick
);
    import timer_pkg::*;

    tick_if ticks ();  // prescaler ticks

    // register state
    logic [7:0] timer_clock_select_r, timer_clock_select_nxt;  // clock select
    logic [7:0] timer_mode_reg_r,     timer_mode_reg_nxt;      // mode fields
    logic [7:0] first_timer_low_byte_r,  first_timer_low_byte_nxt;
    logic [7:0] first_timer_high_byte_r, first_timer_high_byte_nxt;
    logic [7:0] second_timer_low_byte_r, second_timer_low_byte_nxt;
    logic [7:0] second_timer_high_byte_r, second_timer_high_byte_nxt;
    logic       first_timer_run_r,  first_timer_run_nxt;       // run bits
    logic       second_timer_run_r, second_timer_run_nxt;
    logic       first_ovf_flag_r,   first_ovf_flag_nxt;        // overflow flags
    logic       second_ovf_flag_r,  second_ovf_flag_nxt;
    logic [7:0] rdata_r, rdata_nxt;                            // read data
    logic       t1_ovf_r, t1_ovf_nxt;                          // overflow strobe

    // synchronised pins
    logic ev0_fall, ev1_fall;    // event pin falling edges
    logic irq0_lvl, irq1_lvl;    // gate pin levels
    logic ext_rise;              // external clock rising edge

    pin_sync u_ev0 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(first_event_pin),
                    .level(), .fall(ev0_fall), .rise());
    pin_sync u_ev1 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(second_event_pin),
                    .level(), .fall(ev1_fall), .rise());
    pin_sync u_ir0 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(first_external_irq_input),
                    .level(irq0_lvl), .fall(), .rise());
    pin_sync u_ir1 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(second_external_irq_input),
                    .level(irq1_lvl), .fall(), .rise());
    pin_sync u_ext (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ext_osc_clk),
                    .level(), .fall(), .rise(ext_rise));  // R25

    prescaler u_presc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .div_sel (div_sel_t'(timer_clock_select_r[`CKS_DIV_MSB:`CKS_DIV_LSB])),
        .ext_rise(ext_rise),
        .ticks   (ticks)
    );

    // decoded fields
    mode_t mode0, mode1;   // per-timer modes
    logic  split;          // first timer in split mode
    assign mode0 = mode_t'(timer_mode_reg_r[`MD_T0_MSB:`MD_T0_LSB]);  // R21
    assign mode1 = mode_t'(timer_mode_reg_r[`MD_T1_MSB:`MD_T1_LSB]);  // R21
    assign split = (mode0 == MODE_SPLIT);

    // one count step; returns {overflow, high, low}
    function automatic logic [16:0] step(input logic [7:0] hi, input logic [7:0] lo,
                                         input mode_t m);
        logic [12:0] c13;
        logic [16:0] res;
        c13 = 13'h0000;
        res = 17'h00000;
        case (m)
            MODE_13BIT: begin  // R24
                c13 = {hi, lo[4:0]} + 13'h0001;                           // R7
                res = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};  // R8
            end
            MODE_16BIT: begin
                res = {1'b0, hi, lo} + 17'h00001;  // R13
            end
            MODE_8BIT_RELOAD: begin
                if (lo == 8'hFF) begin
                    res = {1'b1, hi, hi};  // R14
                end else begin
                    res = {1'b0, hi, lo + 8'h01};
                end
            end
            default: begin  // split low byte, high byte untouched
                res = {(lo == 8'hFF), hi, lo + 8'h01};  // R16
            end
        endcase
        return res;
    endfunction

    // clock picks; count-select overrides the pick for tick0 and tick1, but not for en0_hi or the split-mode en1
    logic int_tick0, int_tick1;  // internal tick per timer
    logic tick0, tick1;          // chosen tick per timer
    logic gate_ok0, gate_ok1;    // gate pin satisfied
    assign int_tick0 = timer_clock_select_r[`CKS_T0_PICK] ? 1'b1 : ticks.shared_tick;  // R3
    assign int_tick1 = timer_clock_select_r[`CKS_T1_PICK] ? 1'b1 : ticks.shared_tick;  // R2
    assign tick0 = timer_mode_reg_r[`MD_T0_COUNT] ? ev0_fall : int_tick0;  // R9 R3
    assign tick1 = timer_mode_reg_r[`MD_T1_COUNT] ? ev1_fall : int_tick1;  // R9 R2
    assign gate_ok0 = ~timer_mode_reg_r[`MD_T0_GATE] | (irq0_lvl == first_irq_polarity);
    assign gate_ok1 = ~timer_mode_reg_r[`MD_T1_GATE] | (irq1_lvl == second_irq_polarity);  // R12

    // enables: run bit and gate; run never clears the count
    logic en0, en0_hi, en1;  // per-counter enables
    always_comb begin
        en0    = first_timer_run_r & gate_ok0 & tick0;                  // R10 R11
        en0_hi = split & second_timer_run_r & int_tick0;                // R17
        if (mode1 == MODE_SPLIT) begin
            en1 = 1'b0;                                                 // R20 R19
        end else if (split) begin
            en1 = int_tick1;                                            // R19 R18
        end else begin
            en1 = second_timer_run_r & gate_ok1 & tick1;                // R10 R12
        end
    end

    // register write decode
    logic wr_ck, wr_rf, wr_md, wr_l0, wr_h0, wr_l1, wr_h1;  // write selects
    assign wr_ck = sfr_wr_en & (sfr_addr == `ADDR_CLOCK_SELECT);
    assign wr_rf = sfr_wr_en & (sfr_addr == `ADDR_RUN_FLAG);
    assign wr_md = sfr_wr_en & (sfr_addr == `ADDR_MODE);
    assign wr_l0 = sfr_wr_en & (sfr_addr == `ADDR_T0_LOW);
    assign wr_h0 = sfr_wr_en & (sfr_addr == `ADDR_T0_HIGH);
    assign wr_l1 = sfr_wr_en & (sfr_addr == `ADDR_T1_LOW);
    assign wr_h1 = sfr_wr_en & (sfr_addr == `ADDR_T1_HIGH);

    // counter, flag and register next values
    logic [16:0] s0, s1;   // step results
    logic        ovf0_hi;  // split high byte overflow
    logic [7:0]  hi0_inc;  // split high byte increment
    logic        set0, set1;  // hardware flag sets
    always_comb begin
        s0      = step(first_timer_high_byte_r, first_timer_low_byte_r, mode0);
        s1      = step(second_timer_high_byte_r, second_timer_low_byte_r, mode1);
        hi0_inc = first_timer_high_byte_r + 8'h01;
        ovf0_hi = en0_hi & (first_timer_high_byte_r == 8'hFF);

        // hardware updates first
        first_timer_low_byte_nxt   = en0 ? s0[7:0] : first_timer_low_byte_r;
        second_timer_low_byte_nxt  = en1 ? s1[7:0] : second_timer_low_byte_r;
        second_timer_high_byte_nxt = en1 ? s1[15:8] : second_timer_high_byte_r;
        if (split) begin
            first_timer_high_byte_nxt = en0_hi ? hi0_inc : first_timer_high_byte_r;  // R17
        end else begin
            first_timer_high_byte_nxt = en0 ? s0[15:8] : first_timer_high_byte_r;   // R6
        end

        // software byte writes override same-cycle hardware update
        if (wr_l0) begin
            first_timer_low_byte_nxt = sfr_wdata;  // R26 R6
        end
        if (wr_h0) begin
            first_timer_high_byte_nxt = sfr_wdata;  // R26
        end
        if (wr_l1) begin
            second_timer_low_byte_nxt = sfr_wdata;  // R26
        end
        if (wr_h1) begin
            second_timer_high_byte_nxt = sfr_wdata;  // R26
        end

        // flag sources; split mode steers the high byte onto flag two
        set0       = en0 & s0[16];                                  // R8 R16
        set1       = split ? ovf0_hi : (en1 & s1[16]);              // R17 R18
        t1_ovf_nxt = en1 & s1[16];                                  // R18

        timer_clock_select_nxt = wr_ck ? sfr_wdata : timer_clock_select_r;
        timer_mode_reg_nxt     = wr_md ? sfr_wdata : timer_mode_reg_r;
        first_timer_run_nxt    = wr_rf ? sfr_wdata[`RF_T0_RUN] : first_timer_run_r;
        second_timer_run_nxt   = wr_rf ? sfr_wdata[`RF_T1_RUN] : second_timer_run_r;

        // clears from software or vector; a set in the same cycle wins
        first_ovf_flag_nxt = first_ovf_flag_r;
        if (wr_rf) begin
            first_ovf_flag_nxt = sfr_wdata[`RF_T0_FLAG];
        end
        if (first_timer_irq_ack) begin
            first_ovf_flag_nxt = 1'b0;  // R22
        end
        if (set0) begin
            first_ovf_flag_nxt = 1'b1;  // R22
        end
        second_ovf_flag_nxt = second_ovf_flag_r;
        if (wr_rf) begin
            second_ovf_flag_nxt = sfr_wdata[`RF_T1_FLAG];
        end
        if (second_timer_irq_ack) begin
            second_ovf_flag_nxt = 1'b0;  // R22
        end
        if (set1) begin
            second_ovf_flag_nxt = 1'b1;  // R22
        end

        // read mux; unmapped addresses and low control bits read zero
        rdata_nxt = rdata_r;
        if (sfr_rd_en) begin
            case (sfr_addr)
                `ADDR_CLOCK_SELECT: rdata_nxt = timer_clock_select_r;
                `ADDR_MODE:         rdata_nxt = timer_mode_reg_r;
                `ADDR_T0_LOW:       rdata_nxt = first_timer_low_byte_r;
                `ADDR_T0_HIGH:      rdata_nxt = first_timer_high_byte_r;
                `ADDR_T1_LOW:       rdata_nxt = second_timer_low_byte_r;
                `ADDR_T1_HIGH:      rdata_nxt = second_timer_high_byte_r;
                `ADDR_RUN_FLAG:     rdata_nxt = {second_ovf_flag_r, second_timer_run_r,
                                                 first_ovf_flag_r, first_timer_run_r, 4'h0};
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    // register all state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_clock_select_r     <= `RESET_BYTE;
            timer_mode_reg_r         <= `RESET_BYTE;
            first_timer_low_byte_r   <= `RESET_BYTE;
            first_timer_high_byte_r  <= `RESET_BYTE;
            second_timer_low_byte_r  <= `RESET_BYTE;
            second_timer_high_byte_r <= `RESET_BYTE;
            first_timer_run_r        <= 1'b0;
            second_timer_run_r       <= 1'b0;
            first_ovf_flag_r         <= 1'b0;
            second_ovf_flag_r        <= 1'b0;
            rdata_r                  <= `RESET_BYTE;
            t1_ovf_r                 <= 1'b0;
        end else begin
            timer_clock_select_r     <= timer_clock_select_nxt;
            timer_mode_reg_r         <= timer_mode_reg_nxt;
            first_timer_low_byte_r   <= first_timer_low_byte_nxt;
            first_timer_high_byte_r  <= first_timer_high_byte_nxt;
            second_timer_low_byte_r  <= second_timer_low_byte_nxt;
            second_timer_high_byte_r <= second_timer_high_byte_nxt;
            first_timer_run_r        <= first_timer_run_nxt;
            second_timer_run_r       <= second_timer_run_nxt;
            first_ovf_flag_r         <= first_ovf_flag_nxt;
            second_ovf_flag_r        <= second_ovf_flag_nxt;
            rdata_r                  <= rdata_nxt;
            t1_ovf_r                 <= t1_ovf_nxt;
        end
    end

    // interrupt requests follow flag and enable
    assign first_timer_irq_req        = first_ovf_flag_r & first_timer_irq_enable;   // R8
    assign second_timer_irq_req       = second_ovf_flag_r & second_timer_irq_enable;
    assign second_timer_overflow_tick = t1_ovf_r;  // R18
    assign sfr_rdata                  = rdata_r;

    // third and fourth timer clock picks: system clock or their own source
    always_comb begin
        third_timer_low_tick   = timer_clock_select_r[`CKS_T2_LOW] ? 1'b1 :
                                 (third_timer_ext_clock_bit ? ticks.ext8_tick
                                                            : ticks.div12_tick);  // R4
        third_timer_high_tick  = timer_clock_select_r[`CKS_T2_HIGH] ? 1'b1 :
                                 (third_timer_ext_clock_bit ? ticks.ext8_tick
                                                            : ticks.div12_tick);  // R4
        fourth_timer_low_tick  = timer_clock_select_r[`CKS_T3_LOW] ? 1'b1 :
                                 (fourth_timer_ext_clock_bit ? ticks.ext8_tick
                                                             : ticks.div12_tick);  // R5
        fourth_timer_high_tick = timer_clock_select_r[`CKS_T3_HIGH] ? 1'b1 :
                                 (fourth_timer_ext_clock_bit ? ticks.ext8_tick
                                                             : ticks.div12_tick);  // R5
    end
endmodule

// File: test/pin_model.sv
// far-side model that drives the two event pins
`timescale 1ns/1ns
module pin_model (
    input  wire logic sys_clk,          // system clock
    output logic      first_event_pin,  // first event pin, idle high
    output logic      second_event_pin  // second event pin, idle high
);
    // pins rest high so that only a strike gives a falling edge
    initial begin
        first_event_pin = 1'b1;
        second_event_pin = 1'b1;
    end
    // each level held four clocks, twice the sampling minimum
    task automatic strike(input int n);
        repeat (n) begin
            first_event_pin = 1'b0;
            repeat (4) @(negedge sys_clk);
            first_event_pin = 1'b1;
            repeat (4) @(negedge sys_clk);
        end
    endtask
endmodule

// File: test/timer_props.sv
// port-level checker for the timer block
`timescale 1ns/1ns
module timer_props (
    input wire logic       sys_clk, rst_n, sfr_wr_en, sfr_rd_en,          // clock, reset, strobes
    input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,                // register port
    input wire logic       first_timer_irq_enable, first_timer_irq_req,   // first irq
    input wire logic       second_timer_irq_enable, second_timer_irq_req, // second irq
    input wire logic       third_timer_low_tick, fourth_timer_low_tick    // byte ticks
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a write, one idle cycle, then a read of the same place
    sequence wr_rd(logic [7:0] a);
        sfr_wr_en && sfr_addr == a ##1 !sfr_wr_en ##1 sfr_rd_en && !sfr_wr_en && sfr_addr == a;
    endsequence
    property echo(logic [7:0] a);
        wr_rd(a) |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    AST_UNMAPPED_ZERO: assert property (sfr_rd_en && !(sfr_addr inside {[8'h88:8'h8E]})
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    AST_FLAG_NIBBLE: assert property (sfr_rd_en && sfr_addr == 8'h88 |=>
        sfr_rdata[3:0] == 4'h0) else $error("run/flag low nibble not zero");
    AST_CKS_ECHO: assert property (echo(8'h8E)) else $error("clock select readback");
    AST_MODE_ECHO: assert property (echo(8'h89)) else $error("mode readback");
    AST_RDATA_HOLD: assert property (!sfr_rd_en |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    AST_IRQ1_MASK: assert property (!first_timer_irq_enable |-> !first_timer_irq_req)
        else $error("first irq while masked");
    AST_IRQ2_MASK: assert property (!second_timer_irq_enable |-> !second_timer_irq_req)
        else $error("second irq while masked");
    AST_THIRD_SYS: assert property (sfr_wr_en && sfr_addr == 8'h8E && sfr_wdata[4]
        |=> third_timer_low_tick) else $error("third low byte not on system clock");
    AST_FOURTH_SYS: assert property (sfr_wr_en && sfr_addr == 8'h8E && sfr_wdata[6]
        |=> fourth_timer_low_tick) else $error("fourth low byte not on system clock");
endmodule
bind dual_timer_counter timer_props u_timer_props (.*);

// File: test/dual_timer_counter_test.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ns
module dual_timer_counter_test;
    logic       sys_clk = 1'b0, rst_n = 1'b0, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic       first_external_irq_input = 1'b1, second_external_irq_input = 1'b1;
    logic       ext_osc_clk = 1'b0, first_irq_polarity = 1'b1, second_irq_polarity = 1'b1;
    logic       first_timer_irq_enable = 1'b1, second_timer_irq_enable = 1'b1;
    logic       first_timer_irq_ack = 1'b0, second_timer_irq_ack = 1'b0;
    logic       third_timer_ext_clock_bit = 1'b0, fourth_timer_ext_clock_bit = 1'b0;
    logic       first_timer_irq_req, second_timer_irq_req, second_timer_overflow_tick;
    logic       third_timer_low_tick, third_timer_high_tick;
    logic       fourth_timer_low_tick, fourth_timer_high_tick;
    wire        first_event_pin, second_event_pin;
    int         bad_count = 0, compares = 0;
    always #5 sys_clk = ~sys_clk;
    dual_timer_counter u_dual_timer_counter (.*);
    pin_model u_pin_model (.*);
    // one comparison, counted
    task check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // register write, one strobe cycle
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(negedge sys_clk);
        sfr_wr_en = 1'b0;
        @(negedge sys_clk);
    endtask
    // register read, data settled after the read edge
    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        @(negedge sys_clk);
        sfr_rd_en = 0;
        check(sfr_rdata, e);
        @(negedge sys_clk);
    endtask
    // preload first timer, run, strike the pin, read back
    task run_case(input logic [7:0] m, lo, hi, input int n, input logic [7:0] elo, ehi, erf);
        wr_reg(8'h88, 8'h00);
        wr_reg(8'h89, m);
        wr_reg(8'h8A, lo);
        wr_reg(8'h8C, hi);
        wr_reg(8'h88, 8'h10);
        u_pin_model.strike(n);
        rd_reg(8'h8A, elo);
        rd_reg(8'h8C, ehi);
        rd_reg(8'h88, erf);
        check({7'h00, first_timer_irq_req}, {7'h00, erf[5]});
    endtask
    task final_report;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard, far beyond the sequence length
    initial begin
        #1000000;
        bad_count++;
        final_report;
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int a = 8'h88; a <= 8'h8E; a++) rd_reg(a[7:0], 8'h00);
        rd_reg(8'h90, 8'h00);
        wr_reg(8'h89, 8'hA5); rd_reg(8'h89, 8'hA5);
        wr_reg(8'h8E, 8'hF4); rd_reg(8'h8E, 8'hF4);
        check({4'h0, third_timer_low_tick, third_timer_high_tick, fourth_timer_low_tick,
               fourth_timer_high_tick}, 8'h0F);
        run_case(8'h05, 8'hFE, 8'hFF, 3, 8'h01, 8'h00, 8'h30);
        run_case(8'h04, 8'h1E, 8'hFF, 2, 8'h00, 8'h00, 8'h30);
        run_case(8'h06, 8'hFF, 8'h80, 1, 8'h80, 8'h80, 8'h30);
        run_case(8'h07, 8'hFF, 8'h00, 1, 8'h00, 8'h00, 8'h30);
        wr_reg(8'h8C, 8'hFF); wr_reg(8'h88, 8'h40);
        check({7'h00, second_timer_irq_req}, 8'h01);
        first_external_irq_input = 1'b0;
        run_case(8'h0D, 8'h10, 8'h00, 2, 8'h10, 8'h00, 8'h10);
        first_irq_polarity = 1'b0;
        run_case(8'h0D, 8'h10, 8'h00, 2, 8'h12, 8'h00, 8'h10);
        run_case(8'h05, 8'hFF, 8'hFF, 1, 8'h00, 8'h00, 8'h30);
        first_timer_irq_ack = 1'b1;
        @(negedge sys_clk);
        first_timer_irq_ack = 1'b0;
        rd_reg(8'h88, 8'h10);
        final_report;
    end
endmodule
